// *** logic/autoneg_next_page_regs.sv ***
// Next page register pair and status word behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module autoneg_next_page_regs #(
	parameter int ADDR_W = 10
) (
	// Clock, reset and enable
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Arbitration: outgoing page
	input wire logic ack_local_i,
	input wire logic tx_exchanged_i,
	output logic [15:0] tx_page_o,
	// Arbitration: incoming page
	input wire logic rx_page_valid_i,
	input wire logic [15:0] rx_page_i
);
	// Write channel state
	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	// Read channel state
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Page words and status
	logic [15:0] out_word;
	logic [15:0] in_word;
	logic out_fresh;
	logic in_received;
	logic [15:0] tx_page_q;

	// Write decode
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_got_q | aw_hs;
	wire w_have = w_got_q | w_hs;
	wire do_wr = ce_i & aw_have & w_have & ~bvalid_q;
	wire [ADDR_W-1:0] wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_got_q ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
	wire wr_out = wr_addr == ADDR_W'(np_regs_pkg::reg_addr(
		np_regs_pkg::OUT_IDX));
	wire wr_in = wr_addr == ADDR_W'(np_regs_pkg::reg_addr(
		np_regs_pkg::IN_IDX));
	wire wr_stat = wr_addr == ADDR_W'(np_regs_pkg::reg_addr(
		np_regs_pkg::STAT_IDX));
	wire wr_mapped = wr_out | wr_in | wr_stat;

	// Read decode
	wire ar_hs = ce_i & s_axi_arvalid & s_axi_arready;
	wire rd_out = s_axi_araddr == ADDR_W'(np_regs_pkg::reg_addr(
		np_regs_pkg::OUT_IDX));
	wire rd_in = s_axi_araddr == ADDR_W'(np_regs_pkg::reg_addr(
		np_regs_pkg::IN_IDX));
	wire rd_stat = s_axi_araddr == ADDR_W'(np_regs_pkg::reg_addr(
		np_regs_pkg::STAT_IDX));
	wire rd_mapped = rd_out | rd_in | rd_stat;
	wire [15:0] stat_word = {14'h0000, out_fresh, in_received};
	wire [15:0] rd_word = rd_out ? out_word :
		rd_in ? in_word :
		rd_stat ? stat_word : 16'h0000;

	// Reading the incoming word acknowledges the received flag
	wire rx_clear = ar_hs & rd_in;

	// Ready terms; channels are frozen while the enable is low
	assign s_axi_awready = ce_i & ~aw_got_q & ~bvalid_q;
	assign s_axi_wready = ce_i & ~w_got_q & ~bvalid_q;
	assign s_axi_arready = ce_i & ~rvalid_q;

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign tx_page_o = tx_page_q;

	outgoing_word_reg u_out (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.wr_i(do_wr & wr_out),
		.wdata_i(wr_data[15:0]),
		.be_i(wr_strb[1:0]),
		.ack_local_i(ack_local_i),
		.exchanged_i(tx_exchanged_i),
		.word_o(out_word),
		.fresh_o(out_fresh)
	);

	// Received next pages land here, never in the base page register
	incoming_word_reg u_in (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.capture_i(rx_page_valid_i), // [RULE14]
		.page_i(rx_page_i),
		.clear_i(rx_clear),
		.word_o(in_word),
		.received_o(in_received)
	);

	// Page word presented to the arbitration logic
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			tx_page_q <= {np_regs_pkg::FURTHER_RST, 1'b0,
				np_regs_pkg::MESSAGE_RST, np_regs_pkg::COMPLY_RST,
				np_regs_pkg::ALT_RST, np_regs_pkg::CODE_RST};
		else if (ce_i)
			tx_page_q <= out_word; // [RULE1]
	end

	// Write address and data holding
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			aw_got_q <= 1'b0;
			awaddr_q <= '0;
		end else if (ce_i) begin
			if (do_wr)
				aw_got_q <= 1'b0;
			else if (aw_hs) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (ce_i) begin
			if (do_wr)
				w_got_q <= 1'b0;
			else if (w_hs) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// Write response; writes to read-only words are ignored quietly
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= np_regs_pkg::RESP_OKAY;
		end else if (ce_i) begin
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? np_regs_pkg::RESP_OKAY :
					np_regs_pkg::RESP_SLVERR;
			end else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Read response
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= np_regs_pkg::RESP_OKAY;
		end else if (ce_i) begin
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rdata_q <= {16'h0000, rd_word};
				rresp_q <= rd_mapped ? np_regs_pkg::RESP_OKAY :
					np_regs_pkg::RESP_SLVERR;
			end else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end
endmodule

// *** shared/np_regs_pkg.sv ***
// Constants and helpers shared by the next page register bank
// What this block does
// RULE1: Outgoing page word is sent as next page
// RULE2: Bit 15 writable further-page flag, resets 0
// RULE3: Bit 14 read-only local acknowledge status
// RULE4: Bit 13 writable message-page flag, resets 1
// RULE5: Bit 12 writable comply flag, resets 0
// RULE6: Bit 11 alternation bit inverts each exchange
// RULE7: Bits 10:0 carry message or unformatted code
// RULE8: Code field resets to null page 1
// RULE9: Each received next page captured at 0x0008
// RULE10: Incoming bit 15 shows partner further-page wish
// RULE11: Incoming bit 14 shows partner acknowledge
// RULE12: Incoming bit 13 message-page flag, resets 1
// RULE13: Incoming bit 12 shows partner comply flag
// RULE14: Received next pages stored in register 8
// RULE15: Software rewrites outgoing word before each exchange
package np_regs_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] OUT_IDX = 8'h07;
	localparam logic [7:0] IN_IDX = 8'h08;
	localparam logic [7:0] STAT_IDX = 8'h10;

	// Field positions of a page word
	localparam int FURTHER_BIT = 15;
	localparam int ACK_BIT = 14;
	localparam int MESSAGE_BIT = 13;
	localparam int COMPLY_BIT = 12;
	localparam int ALT_BIT = 11;
	localparam int CODE_MSB = 10;
	localparam int CODE_W = 11;

	// Status register fields
	localparam int STAT_RX_BIT = 0;
	localparam int STAT_FRESH_BIT = 1;

	// Reset values
	localparam logic FURTHER_RST = 1'b0;
	localparam logic MESSAGE_RST = 1'b1;
	localparam logic COMPLY_RST = 1'b0;
	localparam logic ALT_RST = 1'b0;
	localparam logic [10:0] CODE_RST = 11'h001;
	localparam logic [15:0] IN_WORD_RST = 16'h2001;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Byte address of a register index
	function automatic logic [9:0] reg_addr(input logic [7:0] idx);
		reg_addr = {idx, 2'h0};
	endfunction

	// Merge two byte lanes of a 16-bit word under strobes
	function automatic logic [15:0] merge_lanes(input logic [15:0] old_w,
			input logic [15:0] new_w, input logic [1:0] be);
		merge_lanes[7:0] = be[0] ? new_w[7:0] : old_w[7:0];
		merge_lanes[15:8] = be[1] ? new_w[15:8] : old_w[15:8];
	endfunction
endpackage

// *** logic/outgoing_word_reg.sv ***
// Outgoing next page word storage and alternation bit
`timescale 1ns/100ps
module outgoing_word_reg (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Software write
	input wire logic wr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [1:0] be_i,
	// Arbitration side
	input wire logic ack_local_i,
	input wire logic exchanged_i,
	output logic [15:0] word_o,
	output logic fresh_o
);
	logic further_q;
	logic message_q;
	logic comply_q;
	logic alt_q;
	logic fresh_q;
	logic [10:0] code_q;
	logic [15:0] merged;

	assign merged = np_regs_pkg::merge_lanes(word_o, wdata_i, be_i);

	// Bits 14 and 11 are not software writable
	assign word_o = {further_q, ack_local_i, message_q, comply_q, // [RULE3]
		alt_q, code_q}; // [RULE1] [RULE7]
	assign fresh_o = fresh_q;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			further_q <= np_regs_pkg::FURTHER_RST; // [RULE2]
			message_q <= np_regs_pkg::MESSAGE_RST; // [RULE4]
			comply_q <= np_regs_pkg::COMPLY_RST; // [RULE5]
			alt_q <= np_regs_pkg::ALT_RST;
			code_q <= np_regs_pkg::CODE_RST; // [RULE8]
			fresh_q <= 1'b0;
		end else if (ce_i) begin
			if (wr_i) begin
				further_q <= merged[np_regs_pkg::FURTHER_BIT]; // [RULE2]
				message_q <= merged[np_regs_pkg::MESSAGE_BIT]; // [RULE4]
				comply_q <= merged[np_regs_pkg::COMPLY_BIT]; // [RULE5]
				code_q <= merged[np_regs_pkg::CODE_MSB:0]; // [RULE7]
			end
			// Next word carries the opposite of the one just exchanged
			if (exchanged_i)
				alt_q <= ~alt_q; // [RULE6]
			// A write landing with an exchange leaves the word fresh
			if (wr_i)
				fresh_q <= 1'b1;
			else if (exchanged_i)
				fresh_q <= 1'b0;
		end
	end
endmodule

// *** logic/incoming_word_reg.sv ***
// Incoming next page word capture with received flag
`timescale 1ns/100ps
module incoming_word_reg (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Arbitration side
	input wire logic capture_i,
	input wire logic [15:0] page_i,
	// Software side
	input wire logic clear_i,
	output logic [15:0] word_o,
	output logic received_o
);
	logic [15:0] word_q;
	logic received_q;

	assign word_o = word_q;
	assign received_o = received_q;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			word_q <= np_regs_pkg::IN_WORD_RST; // [RULE12]
			received_q <= 1'b0;
		end else if (ce_i) begin
			// Whole word kept: bits 15..12 show partner flags
			if (capture_i)
				word_q <= page_i; // [RULE9] [RULE10] [RULE11] [RULE13]
			// New page wins over a simultaneous clear
			if (capture_i)
				received_q <= 1'b1;
			else if (clear_i)
				received_q <= 1'b0;
		end
	end
endmodule

// *** bench/np_regs_checker.sv ***
// Assertions on the next page register bank ports
`timescale 1ns/100ps
module np_regs_checker #(
	parameter int ADDR_W = 10
) (
	// Clock and bus
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Link side
	input wire logic ack_local_i,
	input wire logic tx_exchanged_i,
	input wire logic [15:0] tx_page_o,
	input wire logic rx_page_valid_i,
	input wire logic [15:0] rx_page_i
);
	logic [15:0] in_q;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			in_q <= np_regs_pkg::IN_WORD_RST;
		else if (ce_i && rx_page_valid_i)
			in_q <= rx_page_i;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_reset_value: assert property ($rose(rst_n_i) |-> tx_page_o == 16'h2001)
		else $error("tx page reset value wrong");
	a_ack_live: assert property (ce_i |=> tx_page_o[14] == $past(ack_local_i))
		else $error("ack bit not live");
	a_alt_flip: assert property (tx_exchanged_i && ce_i ##1 ce_i |=> tx_page_o[11] != $past(tx_page_o[11]))
		else $error("alternation bit did not flip");
	a_rx_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h020 && !(rx_page_valid_i && ce_i) |=> s_axi_rdata == {16'h0000, in_q})
		else $error("incoming word read wrong");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_ce_freeze: assert property (!ce_i |=> $stable(tx_page_o))
		else $error("tx page moved while enable low");
	c_exch: cover property (tx_exchanged_i && ce_i);
	c_rx: cover property (rx_page_valid_i && ce_i);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind autoneg_next_page_regs np_regs_checker #(.ADDR_W(ADDR_W)) np_regs_checker_inst (.sys_clk_i, .rst_n_i, .ce_i, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ack_local_i, .tx_exchanged_i, .tx_page_o, .rx_page_valid_i, .rx_page_i);

// *** bench/link_partner_model.sv ***
// Arbitration side stand-in for the remote link partner
`timescale 1ns/100ps
module link_partner_model (
	// Clock
	input wire logic sys_clk_i,
	// Arbitration outputs
	output logic ack_local_o,
	output logic exchanged_o,
	output logic page_valid_o,
	output logic [15:0] page_o
);
	initial begin
		ack_local_o = 1'b0;
		exchanged_o = 1'b0;
		page_valid_o = 1'b0;
		page_o = 16'h0000;
	end
	task automatic send_page(input logic [15:0] p);
		@(posedge sys_clk_i);
		page_o <= p;
		page_valid_o <= 1'b1;
		@(posedge sys_clk_i);
		page_valid_o <= 1'b0;
		page_o <= ~p; // No stale page once released
	endtask
	task automatic exchange(input logic a);
		@(posedge sys_clk_i);
		ack_local_o <= a;
		exchanged_o <= 1'b1;
		@(posedge sys_clk_i);
		exchanged_o <= 1'b0;
	endtask
endmodule

// *** bench/autoneg_next_page_regs_tb.sv ***
// Self-checking bench for the next page register bank
`timescale 1ns/100ps
module autoneg_next_page_regs_tb;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
	logic [2:0] prot = 3'h0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [9:0] awa = 10'h000, ara = 10'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'h0;
	logic awr, wr_rdy, bv, arr, rv, ack, exch, pv;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	logic [15:0] txp, pg;
	int failures = 0, tests_run = 0, cyc = 0;
	always #4 clk = ~clk;
	autoneg_next_page_regs autoneg_next_page_regs_inst (.sys_clk_i(clk),
		.rst_n_i(rst_n), .ce_i(ce), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(prot),
		.s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_arprot(prot), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.ack_local_i(ack), .tx_exchanged_i(exch), .tx_page_o(txp),
		.rx_page_valid_i(pv), .rx_page_i(pg));
	link_partner_model link_partner_model_inst (.sys_clk_i(clk), .ack_local_o(ack), .exchanged_o(exch), .page_valid_o(pv), .page_o(pg));
	task automatic results();
		$display("Checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			failures++;
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
		int n;
		logic ta, tw, done;
		logic [1:0] r;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		ws <= s;
		bry <= 1'b1;
		while (!done && n < 40) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr_rdy;
			done = bv && bry;
			r = br;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
			n++;
		end
		bry <= 1'b0;
		chk("bdone", 32'h1, {31'h0, done});
		chk("bresp", {30'h0, e}, {30'h0, r});
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		logic ta, done;
		logic [31:0] d;
		logic [1:0] r;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		while (!done && n < 40) begin
			@(negedge clk);
			ta = arv && arr;
			done = rv && rry;
			d = rdat;
			r = rr;
			@(posedge clk);
			if (ta)
				arv <= 1'b0;
			n++;
		end
		rry <= 1'b0;
		chk("rdone", 32'h1, {31'h0, done});
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic t_reset();
		rd(10'h01c, 32'h2001, 2'h0);
		rd(10'h020, 32'h2001, 2'h0);
		$display("reset test done");
	endtask
	task automatic t_fields();
		wr(10'h01c, 32'hffffffff, 4'hf, 2'h0);
		rd(10'h01c, 32'hb7ff, 2'h0);
		wr(10'h01c, 32'h0, 4'h1, 2'h0);
		rd(10'h01c, 32'hb700, 2'h0);
		rd(10'h040, 32'h2, 2'h0);
		repeat (2) @(negedge clk);
		chk("tx_page", 32'hb700, {16'h0, txp});
		$display("field test done");
	endtask
	task automatic t_link();
		link_partner_model_inst.exchange(1'b1);
		rd(10'h01c, 32'hff00, 2'h0);
		link_partner_model_inst.exchange(1'b0);
		rd(10'h01c, 32'hb700, 2'h0);
		$display("link test done");
	endtask
	task automatic t_rx();
		link_partner_model_inst.send_page(16'h9abc);
		rd(10'h040, 32'h1, 2'h0);
		rd(10'h020, 32'h9abc, 2'h0);
		rd(10'h040, 32'h0, 2'h0);
		link_partner_model_inst.send_page(16'h4123);
		rd(10'h020, 32'h4123, 2'h0);
		wr(10'h020, 32'h0, 4'hf, 2'h0);
		rd(10'h020, 32'h4123, 2'h0);
		rd(10'h03c, 32'h0, 2'h2);
		wr(10'h03c, 32'h0, 4'hf, 2'h2);
		$display("receive test done");
	endtask
	task automatic t_ce();
		@(posedge clk);
		ce <= 1'b0;
		prot <= 3'h7;
		link_partner_model_inst.exchange(1'b1);
		link_partner_model_inst.send_page(16'h1234);
		@(negedge clk);
		chk("ready_ce", 32'h0, {29'h0, awr, wr_rdy, arr});
		chk("tx_page_ce", 32'hb700, {16'h0, txp});
		@(posedge clk);
		ce <= 1'b1;
		rd(10'h01c, 32'hf700, 2'h0);
		rd(10'h020, 32'h4123, 2'h0);
		rd(10'h040, 32'h0, 2'h0);
		$display("enable test done");
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_fields();
		t_link();
		t_rx();
		t_ce();
		results();
	end
endmodule
